// *** include/rtc_pkg.sv ***
`default_nettype none
package rtc_pkg;
  // register block sits at the top sixteen byte addresses
  localparam logic [10:0] REG_BLOCK    = 11'h7FF;
  localparam logic [15:0] OFF_FLAGS    = 16'h7FF0;
  localparam logic [15:0] OFF_SPARE    = 16'h7FF1;
  localparam logic [15:0] OFF_ALM_SEC  = 16'h7FF2;
  localparam logic [15:0] OFF_ALM_MIN  = 16'h7FF3;
  localparam logic [15:0] OFF_ALM_HOUR = 16'h7FF4;
  localparam logic [15:0] OFF_ALM_DATE = 16'h7FF5;
  localparam logic [15:0] OFF_IRQ_EN   = 16'h7FF6;
  localparam logic [15:0] OFF_WDOG     = 16'h7FF7;
  localparam logic [15:0] OFF_CONTROL  = 16'h7FF8;
  localparam logic [15:0] OFF_SECONDS  = 16'h7FF9;
  localparam logic [15:0] OFF_MINUTES  = 16'h7FFA;
  localparam logic [15:0] OFF_HOURS    = 16'h7FFB;
  localparam logic [15:0] OFF_DAY      = 16'h7FFC;
  localparam logic [15:0] OFF_DATE     = 16'h7FFD;

  // field positions
  localparam int BIT_WRITE_HOLD = 7;
  localparam int BIT_READ_HOLD  = 6;
  localparam int BIT_OSC_STOP   = 7;
  localparam int BIT_FREQ_TEST  = 6;
  localparam int BIT_ALARM_IE   = 7;
  localparam int BIT_ALARM_BE   = 5;
  localparam int BIT_WD_STEER   = 7;
  localparam int BIT_ALM_MASK   = 7;
  localparam int BIT_WF         = 7;
  localparam int BIT_AF         = 6;
  localparam int BIT_BLF        = 4;

  // values after reset
  localparam logic [7:0] RST_WDOG   = 8'h00;
  localparam logic [7:0] RST_IRQ_EN = 8'h00;

  // BCD limits of the counted fields
  localparam logic [6:0] LAST_SEC  = 7'h59;
  localparam logic [6:0] LAST_MIN  = 7'h59;
  localparam logic [6:0] LAST_HOUR = 7'h23;

  // timing derived from the 32.768 kHz oscillator
  localparam int OSC_HZ        = 32768;
  localparam int PRESC_W       = $clog2(OSC_HZ);
  localparam int FT_HZ         = 512;
  localparam int FT_BIT        = $clog2(OSC_HZ / (2 * FT_HZ));
  localparam int WD_BASE_DIV   = 16;
  localparam int WD_BASE_SHIFT = $clog2(OSC_HZ / WD_BASE_DIV);
  localparam int WD_CNT_W      = 22;

  // reset pulse, counted on the system clock
  localparam int CLK_HZ           = 10000000;
  localparam int RST_PULSE_MS     = 100;
  localparam int RST_PULSE_CYCLES = (CLK_HZ / 1000) * RST_PULSE_MS;
endpackage
`default_nettype wire

// *** logic/rtc_alarm_watchdog_control.sv ***
`timescale 1ns/1ns
`default_nettype none

module rtc_alarm_watchdog_control #(
  parameter int RST_PULSE_CYCLES = rtc_pkg::RST_PULSE_CYCLES
) (
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic        osc32k,
  input  wire logic        batteryBackup,
  input  wire logic        powerUpTransition,
  input  wire logic        batteryLow,
  input  wire logic        ceN,
  input  wire logic        oeN,
  input  wire logic        weN,
  input  wire logic [14:0] addr,
  input  wire logic [7:0]  dataIn,
  output logic      [7:0]  dataOut,
  output logic             dataOe,
  output logic             irqFreqOut,
  output logic             irqFreqOutOe,
  output logic             powerResetOut,
  output logic             powerResetOutOe
);

  localparam int PULSE_W = $clog2(RST_PULSE_CYCLES + 1);

  // pulse counter width is fixed at elaboration
  generate
    if (RST_PULSE_CYCLES < 1 || PULSE_W > 24) begin : g_bad_pulse
      $error("reset pulse length out of range");
    end
  endgenerate

  typedef enum logic {WD_COUNT, WD_PULSE} wd_state_e;

  typedef struct packed {
    logic                             oscPrev;
    logic [rtc_pkg::PRESC_W-1:0]      presc;
    logic                             alarmCheck;
    logic [7:0][7:0]                  timeInt;
    logic [7:0][7:0]                  timeExt;
    logic                             writeHoldPrev;
    logic [3:0][7:0]                  alarmReg;
    logic [7:0]                       spare;
    logic [7:0]                       irqEn;
    logic [7:0]                       wdReg;
    logic                             af;
    logic                             wf;
    logic [rtc_pkg::WD_CNT_W-1:0]     wdCount;
    wd_state_e                        wdState;
    logic [PULSE_W-1:0]               pulseCount;
    logic                             accPrev;
    logic [3:0]                       accAddr;
    logic                             accWrite;
    logic [7:0]                       accData;
    logic [7:0]                       dataOut;
  } state_s;

  state_s s;
  state_s next_s;

  logic                         acc;
  logic                         accEnd;
  logic                         wrDone;
  logic                         oscRun;
  logic                         oscEdge;
  logic                         secTick;
  logic                         holdOn;
  logic                         writeHold;
  logic                         flagsNow;
  logic                         wdogNow;
  logic                         alarmHit;
  logic                         alarmIrq;
  logic                         wdIrq;
  logic                         ftOn;
  logic                         wdEnabled;
  logic                         wdRestart;
  logic [3:0]                   cmpSel;
  logic [6:0]                   hourInc;
  logic [rtc_pkg::WD_CNT_W-1:0] wdLimit;

  // BCD increment with wrap to zero after the last value
  function automatic logic [6:0] bcdInc(input logic [6:0] v, input logic [6:0] last);
    logic [6:0] r;
    r = v + 7'h01;
    if (v == last) begin
      r = 7'h00;
    end else if (v[3:0] == 4'h9) begin
      r = {v[6:4] + 3'h1, 4'h0};
    end
    return r;
  endfunction

  // low address nibble matches a register offset
  function automatic logic isReg(input logic [3:0] a, input logic [15:0] off);
    return a == off[3:0];
  endfunction

  // compare enables {date, hours, minutes, seconds} from the mask bits
  function automatic logic [3:0] alarmSelect(input logic [3:0] mask);
    logic [3:0] sel;
    case (mask)
      4'hF:    sel = 4'h0;
      4'hE:    sel = 4'h1;
      4'hC:    sel = 4'h3;
      4'h8:    sel = 4'h7;
      4'h0:    sel = 4'hF;
      default: sel = 4'h0;
    endcase
    return sel;
  endfunction

  // timeout in oscillator edges: multiplier times resolution
  function automatic logic [rtc_pkg::WD_CNT_W-1:0] timeoutEdges(input logic [7:0] r);
    logic [rtc_pkg::WD_CNT_W-1:0] t;
    t = {17'h00000, r[6:2]};
    return t << (rtc_pkg::WD_BASE_SHIFT + 2 * int'(r[1:0]));
  endfunction

  // register read multiplexer
  function automatic logic [7:0] readMux(input state_s st, input logic [3:0] a,
                                         input logic blf);
    logic [7:0] d;
    d = 8'h00;
    if (a[3]) begin
      d = st.timeExt[a[2:0]];
    end else if (isReg(a, rtc_pkg::OFF_FLAGS)) begin
      d[rtc_pkg::BIT_WF]  = st.wf;
      d[rtc_pkg::BIT_AF]  = st.af;
      d[rtc_pkg::BIT_BLF] = blf;
    end else if (isReg(a, rtc_pkg::OFF_SPARE)) begin
      d = st.spare;
    end else if (isReg(a, rtc_pkg::OFF_IRQ_EN)) begin
      d = st.irqEn;
    end else if (isReg(a, rtc_pkg::OFF_WDOG)) begin
      d = st.wdReg;
    end else begin
      d = st.alarmReg[a[1:0] - 2'h2];
    end
    return d;
  endfunction

  // bus decode and status terms
  always_comb begin
    acc       = !ceN && (addr[14:4] == rtc_pkg::REG_BLOCK);
    accEnd    = s.accPrev && (!acc || addr[3:0] != s.accAddr);
    wrDone    = accEnd && s.accWrite;
    flagsNow  = (acc && isReg(addr[3:0], rtc_pkg::OFF_FLAGS))
                || (accEnd && isReg(s.accAddr, rtc_pkg::OFF_FLAGS));
    wdogNow   = (acc && isReg(addr[3:0], rtc_pkg::OFF_WDOG))
                || (accEnd && isReg(s.accAddr, rtc_pkg::OFF_WDOG));
    oscRun    = !s.timeInt[rtc_pkg::OFF_SECONDS[2:0]][rtc_pkg::BIT_OSC_STOP];
    oscEdge   = osc32k && !s.oscPrev && oscRun;
    secTick   = oscEdge && (&s.presc);
    hourInc   = bcdInc({1'b0, s.timeInt[3][5:0]}, rtc_pkg::LAST_HOUR);
    writeHold = s.timeExt[rtc_pkg::OFF_CONTROL[2:0]][rtc_pkg::BIT_WRITE_HOLD];
    holdOn    = writeHold || s.timeExt[rtc_pkg::OFF_CONTROL[2:0]][rtc_pkg::BIT_READ_HOLD];
    cmpSel    = alarmSelect({s.alarmReg[3][rtc_pkg::BIT_ALM_MASK],
                             s.alarmReg[2][rtc_pkg::BIT_ALM_MASK],
                             s.alarmReg[1][rtc_pkg::BIT_ALM_MASK],
                             s.alarmReg[0][rtc_pkg::BIT_ALM_MASK]});
    alarmHit  = s.alarmCheck
                && (!cmpSel[0] || s.alarmReg[0][6:0] == s.timeInt[1][6:0])
                && (!cmpSel[1] || s.alarmReg[1][6:0] == s.timeInt[2][6:0])
                && (!cmpSel[2] || s.alarmReg[2][5:0] == s.timeInt[3][5:0])
                && (!cmpSel[3] || s.alarmReg[3][5:0] == s.timeInt[5][5:0]);
    alarmIrq  = s.af && s.irqEn[rtc_pkg::BIT_ALARM_IE]
                && (!batteryBackup || s.irqEn[rtc_pkg::BIT_ALARM_BE]);
    wdIrq     = s.wf && !s.wdReg[rtc_pkg::BIT_WD_STEER];
    wdEnabled = s.wdReg[6:2] != 5'h00;
    wdLimit   = timeoutEdges(s.wdReg);
    wdRestart = accEnd && isReg(s.accAddr, rtc_pkg::OFF_WDOG);
    ftOn      = oscRun && s.timeInt[rtc_pkg::OFF_DAY[2:0]][rtc_pkg::BIT_FREQ_TEST]
                && !s.irqEn[rtc_pkg::BIT_ALARM_IE]
                && (s.wdReg[rtc_pkg::BIT_WD_STEER] || s.wdReg == 8'h00);
  end

  // next state of the whole block
  always_comb begin
    next_s = s;

    // oscillator divider and seconds counting
    next_s.oscPrev    = osc32k;
    next_s.alarmCheck = secTick;
    if (oscEdge) begin
      next_s.presc = s.presc + 1'b1;
    end
    if (secTick) begin
      next_s.timeInt[1][6:0] = bcdInc(s.timeInt[1][6:0], rtc_pkg::LAST_SEC);
      if (s.timeInt[1][6:0] == rtc_pkg::LAST_SEC) begin
        next_s.timeInt[2][6:0] = bcdInc(s.timeInt[2][6:0], rtc_pkg::LAST_MIN);
        if (s.timeInt[2][6:0] == rtc_pkg::LAST_MIN) begin
          next_s.timeInt[3][5:0] = hourInc[5:0];
        end
      end
    end

    // write hold release loads the counters before the refresh sees them
    next_s.writeHoldPrev = writeHold;
    if (s.writeHoldPrev && !writeHold) begin
      next_s.timeInt = s.timeExt;
    end

    // visible copy follows the counters unless held
    if (!holdOn) begin
      next_s.timeExt = {next_s.timeInt[7:1],
                        s.timeExt[0][7:6], next_s.timeInt[0][5:0]};
    end

    // bus access tracking; writes land when the access ends
    next_s.accPrev  = acc;
    next_s.accAddr  = addr[3:0];
    next_s.accWrite = acc && (!weN || (s.accPrev && !accEnd && s.accWrite));
    if (acc && !weN) begin
      next_s.accData = dataIn;
    end
    next_s.dataOut = readMux(s, addr[3:0], batteryLow);

    if (wrDone) begin
      if (s.accAddr[3]) begin
        next_s.timeExt[s.accAddr[2:0]] = s.accData;
        if (!holdOn || isReg(s.accAddr, rtc_pkg::OFF_CONTROL)) begin
          next_s.timeInt[s.accAddr[2:0]] = s.accData;
        end
      end else if (isReg(s.accAddr, rtc_pkg::OFF_SPARE)) begin
        next_s.spare = s.accData;
      end else if (isReg(s.accAddr, rtc_pkg::OFF_IRQ_EN)) begin
        next_s.irqEn = s.accData;
      end else if (isReg(s.accAddr, rtc_pkg::OFF_WDOG)) begin
        next_s.wdReg = s.accData;
      end else if (!isReg(s.accAddr, rtc_pkg::OFF_FLAGS)) begin
        next_s.alarmReg[s.accAddr[1:0] - 2'h2] = s.accData;
      end
    end

    // enables held clear through the power-up transition
    if (powerUpTransition) begin
      next_s.irqEn[rtc_pkg::BIT_ALARM_IE] = 1'b0;
      next_s.irqEn[rtc_pkg::BIT_ALARM_BE] = 1'b0;
    end

    // alarm flag: cleared at end of a flags access, a match wins
    if (accEnd && isReg(s.accAddr, rtc_pkg::OFF_FLAGS)) begin
      next_s.af = 1'b0;
      next_s.wf = 1'b0;
    end
    if (wdRestart) begin
      next_s.wf = 1'b0;
    end
    if (alarmHit) begin
      next_s.af = 1'b1;
    end

    // watchdog counting and steered reset pulse
    case (s.wdState)
      WD_COUNT: begin
        if (wdRestart || !wdEnabled) begin
          next_s.wdCount = '0;
        end else if (oscEdge) begin
          if (s.wdCount >= wdLimit - 1'b1) begin
            next_s.wdCount = '0;
            next_s.wf      = 1'b1;
            if (s.wdReg[rtc_pkg::BIT_WD_STEER]) begin
              next_s.wdState    = WD_PULSE;
              next_s.pulseCount = '0;
            end
          end else begin
            next_s.wdCount = s.wdCount + 1'b1;
          end
        end
      end
      WD_PULSE: begin
        next_s.pulseCount = s.pulseCount + 1'b1;
        if (s.pulseCount == PULSE_W'(RST_PULSE_CYCLES - 1)) begin
          next_s.wdState = WD_COUNT;
          next_s.wdReg   = 8'h00;
          next_s.timeInt[rtc_pkg::OFF_DAY[2:0]][rtc_pkg::BIT_FREQ_TEST] = 1'b0;
          next_s.timeExt[rtc_pkg::OFF_DAY[2:0]][rtc_pkg::BIT_FREQ_TEST] = 1'b0;
        end
      end
      default: begin
        next_s.wdState = WD_COUNT;
      end
    endcase
  end

  // state register; power application zeroes all control bits
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s       <= '0;
      s.wdReg <= rtc_pkg::RST_WDOG;
      s.irqEn <= rtc_pkg::RST_IRQ_EN;
    end else begin
      s <= next_s;
    end
  end

  // pin drive; pull enables high while the pin is pulled low
  assign dataOut         = s.dataOut;
  assign dataOe          = acc && !oeN && weN;
  assign irqFreqOut      = 1'b0;
  assign irqFreqOutOe    = ((alarmIrq && !flagsNow) || (wdIrq && !flagsNow && !wdogNow))
                           || (ftOn && !s.presc[rtc_pkg::FT_BIT]);
  assign powerResetOut   = 1'b0;
  assign powerResetOutOe = s.wdState == WD_PULSE;

endmodule

`default_nettype wire

// *** verif/rtc_alarm_watchdog_control_assertions.sv ***
`timescale 1ns/1ns
`default_nettype none
module rtc_alarm_watchdog_control_assertions #(
  parameter int RST_PULSE_CYCLES = 20
) (
  input wire logic        clk_sys,
  input wire logic        rstn,
  input wire logic        batteryLow,
  input wire logic        ceN,
  input wire logic        oeN,
  input wire logic        weN,
  input wire logic [14:0] addr,
  input wire logic [7:0]  dataOut,
  input wire logic        dataOe,
  input wire logic        irqFreqOut,
  input wire logic        irqFreqOutOe,
  input wire logic        powerResetOut,
  input wire logic        powerResetOutOe
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  int pulseLen;
  // cycles the reset pin has been pulled so far
  always_ff @(posedge clk_sys) begin
    pulseLen <= (!rstn || !powerResetOutOe) ? 0 : pulseLen + 1;
  end
  sequence s_flags_acc;
    !ceN && addr == 15'h7FF0;
  endsequence
  sequence s_spare_read;
    (!ceN && addr == 15'h7FF1 && weN) [*2];
  endsequence
  a_read_drive_decode: assert property (dataOe == (!ceN && addr[14:4] == 11'h7FF && !oeN && weN))
    else $error("data drive enable wrong");
  a_pin_levels: assert property (irqFreqOut == 1'b0 && powerResetOut == 1'b0)
    else $error("open drain level not low");
  a_reset_idle_pins: assert property ($rose(rstn) |-> !irqFreqOutOe && !powerResetOutOe)
    else $error("pin pulled right after reset");
  a_pulse_length: assert property ($fell(powerResetOutOe) |-> pulseLen == RST_PULSE_CYCLES)
    else $error("reset pulse length wrong");
  a_pulse_no_repeat: assert property ($fell(powerResetOutOe) |-> !powerResetOutOe [*8])
    else $error("reset pulse repeats");
  a_flags_zero_bits: assert property (s_flags_acc |=> dataOut[5] == 1'b0 && dataOut[3:0] == 4'h0)
    else $error("flags constant bits not zero");
  a_flags_low_batt: assert property (s_flags_acc |=> dataOut[4] == $past(batteryLow))
    else $error("battery low bit wrong");
  a_spare_stable: assert property (s_spare_read |=> $stable(dataOut))
    else $error("spare byte changes on read");
endmodule
`default_nettype wire

// *** verif/rtc_alarm_watchdog_control_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module rtc_alarm_watchdog_control_tb;
  localparam int RST_P = 20;
  logic        clk_sys = 1'b0;
  logic        rstn = 1'b0;
  logic        osc32k = 1'b0;
  logic        batteryLow = 1'b0;
  logic        batteryBackup = 1'b0;
  logic        powerUpTransition = 1'b0;
  logic        ceN;
  logic        oeN;
  logic        weN;
  logic [14:0] addr;
  logic [7:0]  dataIn;
  logic [7:0]  dataOut;
  logic        dataOe;
  logic        irqFreqOut;
  logic        irqFreqOutOe;
  logic        powerResetOut;
  logic        powerResetOutOe;
  logic [7:0]  d;
  logic        irq;
  int          mismatches = 0;
  int          total_checks = 0;
  int          cycles = 0;
  int          n;
  int          r;
  rtc_alarm_watchdog_control #(.RST_PULSE_CYCLES(RST_P)) uut (
    .clk_sys(clk_sys), .rstn(rstn), .osc32k(osc32k), .batteryBackup(batteryBackup),
    .powerUpTransition(powerUpTransition), .batteryLow(batteryLow), .ceN(ceN), .oeN(oeN),
    .weN(weN), .addr(addr), .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe),
    .irqFreqOut(irqFreqOut), .irqFreqOutOe(irqFreqOutOe), .powerResetOut(powerResetOut),
    .powerResetOutOe(powerResetOutOe));
  rtc_host_model host (
    .clk_sys(clk_sys), .dataOut(dataOut), .irqFreqOutOe(irqFreqOutOe), .ceN(ceN),
    .oeN(oeN), .weN(weN), .addr(addr), .dataIn(dataIn));
  // clock, fast oscillator and hang guard
  always #50 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    osc32k <= ~osc32k;
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  // expected pin edges in frequency test, one osc edge per two clocks
  function automatic int ftEdges(input int cyc);
    return cyc / 64;
  endfunction
  // expected watchdog timeout in clocks
  function automatic int wdCycles(input logic [7:0] w);
    return (int'(w[6:2]) << (11 + 2 * int'(w[1:0]))) * 2;
  endfunction
  task automatic check8(input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  task automatic checkRange(input int v, input int lo, input int hi);
    total_checks++;
    if (v < lo || v > hi) begin
      mismatches++;
      $display("Error t=%0t exp=%h..%h got=%h", $time, lo, hi, v);
    end
  endtask
  task automatic rdChk(input logic [14:0] a, input logic [7:0] m, input logic [7:0] exp);
    host.read(a, d, irq);
    check8(exp, d & m);
  endtask
  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask
  task automatic waitHigh(input logic sel, input int limit, output int cnt);
    cnt = 0;
    while ((sel ? powerResetOutOe : irqFreqOutOe) !== 1'b1 && cnt < limit) begin
      tick();
      cnt++;
    end
  endtask
  // pin changes over a window, after the last write has landed
  task automatic toggles(input int cyc, output int t);
    logic last;
    tick();
    tick();
    t = 0;
    last = irqFreqOutOe;
    repeat (cyc) begin
      tick();
      if (irqFreqOutOe !== last) t++;
      last = irqFreqOutOe;
    end
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    r = $urandom(32'h0D94);
    repeat (20) @(posedge clk_sys);
    rstn <= 1'b1;
    tick();
    rdChk(15'h7FF7, 8'hFF, 8'h00);
    rdChk(15'h7FF6, 8'hA0, 8'h00);
    rdChk(15'h7FFC, 8'h40, 8'h00);
    repeat (4) begin
      r = $urandom();
      batteryLow <= r[8];
      host.write(15'h7FF1, r[7:0]);
      rdChk(15'h7FF1, 8'hFF, r[7:0]);
      rdChk(15'h7FF0, 8'h10, {3'b000, r[8], 4'h0});
    end
    host.write(15'h7FF8, 8'h80);
    host.write(15'h7FF9, 8'h30);
    host.write(15'h7FF8, 8'h00);
    rdChk(15'h7FF9, 8'hFF, 8'h30);
    host.write(15'h7FFC, 8'h40);
    toggles(640, n);
    checkRange(n, ftEdges(640) - 1, ftEdges(640) + 1);
    host.write(15'h7FF9, 8'h80);
    toggles(200, n);
    checkRange(n, 0, 0);
    host.write(15'h7FF9, 8'h30);
    host.write(15'h7FF6, 8'h80);
    toggles(200, n);
    checkRange(n, 0, 0);
    host.write(15'h7FF6, 8'h00);
    host.write(15'h7FF7, 8'h04);
    toggles(3000, n);
    checkRange(n, 0, 0);
    rdChk(15'h7FF7, 8'hFF, 8'h04);
    waitHigh(1'b0, 5000, n);
    checkRange(n, wdCycles(8'h04) - 50, wdCycles(8'h04) + 50);
    repeat (8) tick();
    check8(8'h01, {7'h00, irqFreqOutOe});
    rdChk(15'h7FF0, 8'h80, 8'h80);
    check8(8'h00, {7'h00, irq});
    tick();
    check8(8'h00, {7'h00, irqFreqOutOe});
    host.write(15'h7FFC, 8'h00);
    host.write(15'h7FF7, 8'h00);
    toggles(4500, n);
    checkRange(n, 0, 0);
    host.write(15'h7FFC, 8'h40);
    host.write(15'h7FF7, 8'h84);
    waitHigh(1'b1, 5000, n);
    checkRange(n, wdCycles(8'h84) - 50, wdCycles(8'h84) + 50);
    n = 0;
    while (powerResetOutOe === 1'b1 && n < 100) begin
      tick();
      n++;
    end
    checkRange(n, RST_P, RST_P);
    rdChk(15'h7FF7, 8'hFF, 8'h00);
    rdChk(15'h7FFC, 8'h40, 8'h00);
    host.write(15'h7FF2, 8'h80);
    host.write(15'h7FF6, 8'h80);
    host.write(15'h7FF8, 8'h40);
    waitHigh(1'b0, 70000, n);
    checkRange(n, 1, 69999);
    rdChk(15'h7FF9, 8'hFF, 8'h30);
    host.write(15'h7FF8, 8'h00);
    repeat (2) tick();
    rdChk(15'h7FF9, 8'hFF, 8'h31);
    // backup mode needs both enables, power-up clears them
    @(posedge clk_sys) batteryBackup <= 1'b1;
    tick();
    check8(8'h00, {7'h00, irqFreqOutOe});
    host.write(15'h7FF6, 8'hA0);
    tick();
    check8(8'h01, {7'h00, irqFreqOutOe});
    @(posedge clk_sys) powerUpTransition <= 1'b1;
    tick();
    check8(8'h00, {7'h00, irqFreqOutOe});
    @(posedge clk_sys) powerUpTransition <= 1'b0;
    batteryBackup <= 1'b0;
    rdChk(15'h7FF6, 8'hA0, 8'h00);
    host.write(15'h7FF6, 8'h80);
    tick();
    check8(8'h01, {7'h00, irqFreqOutOe});
    rdChk(15'h7FF0, 8'h40, 8'h40);
    check8(8'h00, {7'h00, irq});
    rdChk(15'h7FF0, 8'h40, 8'h00);
    tick();
    check8(8'h00, {7'h00, irqFreqOutOe});
    tally_and_finish();
  end
endmodule
bind rtc_alarm_watchdog_control rtc_alarm_watchdog_control_assertions #(
  .RST_PULSE_CYCLES(RST_PULSE_CYCLES)) chk (
  .clk_sys(clk_sys), .rstn(rstn), .batteryLow(batteryLow), .ceN(ceN), .oeN(oeN),
  .weN(weN), .addr(addr), .dataOut(dataOut), .dataOe(dataOe), .irqFreqOut(irqFreqOut),
  .irqFreqOutOe(irqFreqOutOe), .powerResetOut(powerResetOut),
  .powerResetOutOe(powerResetOutOe));
`default_nettype wire

// *** verif/rtc_host_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module rtc_host_model (
  input  wire logic        clk_sys,
  input  wire logic [7:0]  dataOut,
  input  wire logic        irqFreqOutOe,
  output logic             ceN,
  output logic             oeN,
  output logic             weN,
  output logic      [14:0] addr,
  output logic      [7:0]  dataIn
);
  // idle bus at time zero
  initial begin
    ceN    = 1'b1;
    oeN    = 1'b1;
    weN    = 1'b1;
    addr   = 15'h0000;
    dataIn = 8'h00;
  end
  // write held over one edge, committed as the select drops
  task automatic write(input logic [14:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    ceN    <= 1'b0;
    weN    <= 1'b0;
    addr   <= a;
    dataIn <= d;
    @(posedge clk_sys);
    ceN    <= 1'b1;
    weN    <= 1'b1;
    dataIn <= ~d;
  endtask
  // read held over two edges so a flags access releases the pin
  task automatic read(input logic [14:0] a, output logic [7:0] d, output logic irq);
    @(posedge clk_sys);
    ceN  <= 1'b0;
    oeN  <= 1'b0;
    addr <= a;
    @(posedge clk_sys);
    @(posedge clk_sys);
    d    = dataOut;
    irq  = irqFreqOutOe;
    ceN  <= 1'b1;
    oeN  <= 1'b1;
    addr <= ~a;
  endtask
endmodule
`default_nettype wire
